/* common/ofsc_params.svh */
`ifndef OFSC_PARAMS_SVH
`define OFSC_PARAMS_SVH
// Overview of operation
// R01 - every clock output stoppable low, except bank C first and feedback outputs
// R02 - each freezable output owns one enable bit of a twelve bit shift register
// R03 - transfer is a low start bit then twelve NRZ enable bits
// R04 - driver presents one bit per serial clock, stable at rising edge
// R05 - enable bit zero stops its output, one lets it run
// R06 - freeze states unchanged until all twelve enable bits shifted in
// R07 - after twelfth bit, next rising serial edge applies the new settings
// R08 - low bit right after twelfth starts next transfer, else wait for low
// R09 - stopping output falls at its natural falling edge, then held low
// R10 - released output goes high only at its natural rising edge
// R11 - undriven control inputs read high through internal pull-ups; the module has none, its control inputs are plain wires
// R12 - first bit after start bit maps to first freezable output, fixed order

// ***********************************
// sizes and reset values
// ***********************************
`define OFSC_NUM_FRZ    12
`define OFSC_CNT_W      4
`define OFSC_CNT_FIRST  4'h0
`define OFSC_CNT_LAST   4'hB
`define OFSC_EN_RESET   12'hFFF
`define OFSC_START_BIT  1'h0
`endif

/* common/ofsc_pkg.sv */
`include "ofsc_params.svh"

package ofsc_pkg;

    // ***********************************
    // link side state
    // ***********************************
    typedef enum logic [1:0] {
        LNK_IDLE,
        LNK_SHIFT,
        LNK_APPLY
    } ofsc_link_st_type;

    typedef struct packed {
        logic                       rst_s1;
        logic                       rst_s2;
        ofsc_link_st_type           st;
        logic [`OFSC_CNT_W-1:0]     cnt;
        logic [`OFSC_NUM_FRZ-1:0]   shreg;
        logic [`OFSC_NUM_FRZ-1:0]   applied;
        logic                       tog;
    } ofsc_link_type;

    // ***********************************
    // core side state
    // ***********************************
    typedef struct packed {
        logic                       tog_s1;
        logic                       tog_s2;
        logic                       tog_s3;
        logic [`OFSC_NUM_FRZ-1:0]   en;
        logic [`OFSC_NUM_FRZ-1:0]   gate;
        logic [`OFSC_NUM_FRZ-1:0]   frz_out;
        logic                       bank_c_first;
        logic                       feedback;
    } ofsc_core_type;

endpackage : ofsc_pkg

/* core/ofsc_top.sv */
`timescale 1ns/100ps
`include "ofsc_params.svh"

module ofsc_top #(
    parameter int NUM_FRZ = `OFSC_NUM_FRZ
) (
    input  wire logic               CORE_CLK,
    input  wire logic               RST,
    input  wire logic               FREEZE_SERIAL_CLOCK,
    input  wire logic               FREEZE_SERIAL_DATA,
    input  wire logic [NUM_FRZ-1:0] FREEZABLE_CLOCKS_IN,
    input  wire logic               BANK_C_FIRST_IN,
    input  wire logic               FEEDBACK_IN,
    output logic      [NUM_FRZ-1:0] FREEZABLE_CLOCKS_OUT,
    output logic                    BANK_C_FIRST_OUTPUT,
    output logic                    FEEDBACK_OUTPUT,
    output logic      [NUM_FRZ-1:0] FREEZE_ENABLES
);

    // ***********************************
    // elaboration checks
    // ***********************************
    if (NUM_FRZ != `OFSC_NUM_FRZ) begin : g_bad_width
        $error("NUM_FRZ must match the shift register width of the package");
    end

    // ***********************************
    // link domain: serial receiver
    // ***********************************
    // runs on the serial clock itself; that clock may stop between transfers,
    // which is harmless since the applied word is simply held
    ofsc_pkg::ofsc_link_type l;
    ofsc_pkg::ofsc_link_type next_l;

    always_comb begin
        next_l = l;
        next_l.rst_s1 = RST;
        next_l.rst_s2 = l.rst_s1;
        if (l.rst_s2) begin
            next_l.st      = ofsc_pkg::LNK_IDLE;
            next_l.cnt     = `OFSC_CNT_FIRST;
            next_l.shreg   = `OFSC_EN_RESET;
            next_l.applied = `OFSC_EN_RESET;
            next_l.tog     = 1'h0;
        end else begin
            case (l.st)
                ofsc_pkg::LNK_IDLE: begin
                    // the module has no pull-up: a floating data pin reads z, fails the start-bit compare and idles here [R11]
                    if (FREEZE_SERIAL_DATA == `OFSC_START_BIT) begin // [R03]
                        next_l.st  = ofsc_pkg::LNK_SHIFT;
                        next_l.cnt = `OFSC_CNT_FIRST;
                    end
                end
                ofsc_pkg::LNK_SHIFT: begin
                    // data sampled on rising serial edge, driver keeps it stable there [R04]
                    next_l.shreg[l.cnt] = FREEZE_SERIAL_DATA; // [R02] [R12]
                    if (l.cnt == `OFSC_CNT_LAST) begin
                        next_l.st = ofsc_pkg::LNK_APPLY; // [R06]
                    end else begin
                        next_l.cnt = l.cnt + `OFSC_CNT_W'(1);
                    end
                end
                ofsc_pkg::LNK_APPLY: begin
                    next_l.applied = l.shreg; // [R07]
                    next_l.tog     = ~l.tog;
                    if (FREEZE_SERIAL_DATA == `OFSC_START_BIT) begin // [R08]
                        next_l.st  = ofsc_pkg::LNK_SHIFT;
                        next_l.cnt = `OFSC_CNT_FIRST;
                    end else begin
                        next_l.st = ofsc_pkg::LNK_IDLE; // [R08]
                    end
                end
                default: begin
                    next_l.st = ofsc_pkg::LNK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge FREEZE_SERIAL_CLOCK) begin
        l <= next_l;
    end

    // ***********************************
    // core domain: crossing and gating
    // ***********************************
    // the applied word only changes thirteen serial clocks apart at the least,
    // far longer than the toggle needs to cross, so it is read as a held bus
    ofsc_pkg::ofsc_core_type c;
    ofsc_pkg::ofsc_core_type next_c;

    always_comb begin
        next_c = c;
        next_c.tog_s1 = l.tog;
        next_c.tog_s2 = c.tog_s1;
        next_c.tog_s3 = c.tog_s2;
        if (RST) begin
            next_c.en           = `OFSC_EN_RESET;
            next_c.gate         = `OFSC_EN_RESET;
            next_c.frz_out      = '0;
            next_c.bank_c_first = 1'h0;
            next_c.feedback     = 1'h0;
        end else begin
            if (c.tog_s3 != c.tog_s2) begin
                next_c.en = l.applied; // [R07]
            end
            for (int i = 0; i < NUM_FRZ; i++) begin
                // gate may only move while the source clock is low: entry waits for the
                // natural fall, exit lets the next natural rise through whole [R09] [R10]
                if (!FREEZABLE_CLOCKS_IN[i]) begin
                    next_c.gate[i] = c.en[i]; // [R05]
                end
                next_c.frz_out[i] = FREEZABLE_CLOCKS_IN[i] & next_c.gate[i]; // [R01]
            end
            // same register stage keeps these aligned with the gated outputs [R01]
            next_c.bank_c_first = BANK_C_FIRST_IN;
            next_c.feedback     = FEEDBACK_IN;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        c <= next_c;
    end

    assign FREEZABLE_CLOCKS_OUT = c.frz_out;
    assign BANK_C_FIRST_OUTPUT  = c.bank_c_first;
    assign FEEDBACK_OUTPUT      = c.feedback;
    assign FREEZE_ENABLES       = c.en;

    // ***********************************
    // checks: link domain
    // ***********************************
    sequence s_start_seen;
        (l.st == ofsc_pkg::LNK_IDLE) && (FREEZE_SERIAL_DATA == `OFSC_START_BIT);
    endsequence

    sequence s_twelve_shifts;
        (l.st == ofsc_pkg::LNK_SHIFT) [*8] ##1 (l.st == ofsc_pkg::LNK_SHIFT) [*4];
    endsequence

    chk_start_then_twelve: assert property ( // [R03]
        @(posedge FREEZE_SERIAL_CLOCK) disable iff (l.rst_s2)
        s_start_seen |=> s_twelve_shifts ##1 (l.st == ofsc_pkg::LNK_APPLY))
        else $error("twelve shifts did not follow a start bit");

    chk_hold_while_shift: assert property ( // [R06]
        @(posedge FREEZE_SERIAL_CLOCK) disable iff (l.rst_s2)
        (l.st != ofsc_pkg::LNK_APPLY) |=> $stable(l.applied) && $stable(l.tog))
        else $error("applied word changed before transfer completed");

    chk_apply_word_next: assert property ( // [R07]
        @(posedge FREEZE_SERIAL_CLOCK) disable iff (l.rst_s2)
        (l.st == ofsc_pkg::LNK_APPLY) |=> (l.applied == $past(l.shreg)) && (l.tog != $past(l.tog)))
        else $error("word not applied on edge after twelfth bit");

    chk_back_to_back: assert property ( // [R08]
        @(posedge FREEZE_SERIAL_CLOCK) disable iff (l.rst_s2)
        (l.st == ofsc_pkg::LNK_APPLY) |=>
            (($past(FREEZE_SERIAL_DATA) == `OFSC_START_BIT) ?
             (l.st == ofsc_pkg::LNK_SHIFT && l.cnt == `OFSC_CNT_FIRST) :
             (l.st == ofsc_pkg::LNK_IDLE)))
        else $error("bit after twelfth not handled as start or idle");

    chk_idle_high_wait: assert property ( // [R11]
        @(posedge FREEZE_SERIAL_CLOCK) disable iff (l.rst_s2)
        (l.st == ofsc_pkg::LNK_IDLE) && FREEZE_SERIAL_DATA |=> (l.st == ofsc_pkg::LNK_IDLE))
        else $error("high data left idle");

    chk_first_bit_order: assert property ( // [R12]
        @(posedge FREEZE_SERIAL_CLOCK) disable iff (l.rst_s2)
        s_start_seen ##1 (l.st == ofsc_pkg::LNK_SHIFT) |=> (l.shreg[0] == $past(FREEZE_SERIAL_DATA)))
        else $error("first bit after start not in bit zero");

    // ***********************************
    // checks: core domain
    // ***********************************
    // the antecedent reads RST as sampled, so the edge that releases reset is not judged
    chk_always_running: assert property ( // [R01]
        @(posedge CORE_CLK) disable iff (RST)
        !RST |=> (BANK_C_FIRST_OUTPUT == $past(BANK_C_FIRST_IN)) && (FEEDBACK_OUTPUT == $past(FEEDBACK_IN)))
        else $error("always running output not following its source");

    chk_frozen_low: assert property ( // [R05]
        @(posedge CORE_CLK) disable iff (RST)
        ((FREEZABLE_CLOCKS_OUT & ~c.gate) == '0) && ((c.gate & ~$past(c.en) & $past(~FREEZABLE_CLOCKS_IN)) == '0))
        else $error("stopped output not low or gate ignored enable");

    chk_no_runt_fall: assert property ( // [R09]
        @(posedge CORE_CLK) disable iff (RST)
        ##2 (!$past(RST) && !$past(RST, 2)) |->
            (($past(FREEZABLE_CLOCKS_OUT) & ~FREEZABLE_CLOCKS_OUT & $past(FREEZABLE_CLOCKS_IN)) == '0))
        else $error("output fell while its source was high");

    chk_no_runt_rise: assert property ( // [R10]
        @(posedge CORE_CLK) disable iff (RST)
        ##2 (!$past(RST) && !$past(RST, 2)) |->
            ((~$past(FREEZABLE_CLOCKS_OUT) & FREEZABLE_CLOCKS_OUT & $past(FREEZABLE_CLOCKS_IN, 2)) == '0))
        else $error("output rose away from a natural rising edge");

    chk_enable_crossed: assert property ( // [R02]
        @(posedge CORE_CLK) disable iff (RST)
        (c.tog_s3 != c.tog_s2) |=> (FREEZE_ENABLES == $past(l.applied)))
        else $error("enable word not taken after toggle");

    // the held-bus crossing is only safe while the word stays put once the toggle is seen
    chk_word_held_cross: assert property ( // [R07]
        @(posedge CORE_CLK) disable iff (RST)
        (c.tog_s3 != c.tog_s2) |-> $stable(l.applied))
        else $error("applied word moved while being taken");

    chk_toggle_single: assert property ( // [R07]
        @(posedge CORE_CLK) disable iff (RST)
        (c.tog_s3 != c.tog_s2) |=> (c.tog_s3 == c.tog_s2))
        else $error("enable word taken twice for one toggle");

    // ***********************************
    // checks: reset values
    // ***********************************
    chk_core_reset: assert property ( // [R05]
        @(posedge CORE_CLK)
        RST |=> (FREEZE_ENABLES == `OFSC_EN_RESET) && (FREEZABLE_CLOCKS_OUT == '0)
                && !BANK_C_FIRST_OUTPUT && !FEEDBACK_OUTPUT)
        else $error("core outputs not at reset values");

    // the receiver only resets while the serial clock runs; a stopped clock keeps its state
    chk_link_reset: assert property ( // [R08]
        @(posedge FREEZE_SERIAL_CLOCK)
        l.rst_s2 |=> (l.st == ofsc_pkg::LNK_IDLE) && (l.applied == `OFSC_EN_RESET))
        else $error("receiver not idle after reset");

    // ***********************************
    // checks: shift counter
    // ***********************************
    sequence s_mid_shift;
        (l.st == ofsc_pkg::LNK_SHIFT) && (l.cnt != `OFSC_CNT_LAST);
    endsequence

    sequence s_last_shift;
        (l.st == ofsc_pkg::LNK_SHIFT) && (l.cnt == `OFSC_CNT_LAST);
    endsequence

    chk_count_in_range: assert property ( // [R02]
        @(posedge FREEZE_SERIAL_CLOCK) disable iff (l.rst_s2)
        (l.st == ofsc_pkg::LNK_SHIFT) |-> (l.cnt <= `OFSC_CNT_LAST))
        else $error("shift counter beyond last enable bit");

    chk_count_steps: assert property ( // [R02]
        @(posedge FREEZE_SERIAL_CLOCK) disable iff (l.rst_s2)
        s_mid_shift |=> (l.st == ofsc_pkg::LNK_SHIFT) && (l.cnt == $past(l.cnt) + `OFSC_CNT_W'(1)))
        else $error("shift counter skipped a bit");

    chk_last_to_apply: assert property ( // [R06]
        @(posedge FREEZE_SERIAL_CLOCK) disable iff (l.rst_s2)
        s_last_shift |=> (l.st == ofsc_pkg::LNK_APPLY))
        else $error("twelfth bit not followed by apply");

    chk_bit_lands: assert property ( // [R12]
        @(posedge FREEZE_SERIAL_CLOCK) disable iff (l.rst_s2)
        (l.st == ofsc_pkg::LNK_SHIFT) |=> (l.shreg[$past(l.cnt)] == $past(FREEZE_SERIAL_DATA)))
        else $error("enable bit not stored at its position");

    // ***********************************
    // checks: per output gating
    // ***********************************
    // one copy per freezable output so that a failure names its channel
    for (genvar g = 0; g < NUM_FRZ; g++) begin : g_chan_chk
        sequence s_src_high_twice;
            (!RST && FREEZABLE_CLOCKS_IN[g]) ##1 FREEZABLE_CLOCKS_IN[g];
        endsequence

        chk_gate_high_still: assert property ( // [R09] [R10]
            @(posedge CORE_CLK) disable iff (RST)
            (!RST && FREEZABLE_CLOCKS_IN[g]) |=> $stable(c.gate[g]))
            else $error("gate moved while its source was high");

        chk_frozen_stays_low: assert property ( // [R05] [R09]
            @(posedge CORE_CLK) disable iff (RST)
            (!RST && !c.en[g] && !c.gate[g]) |=> !FREEZABLE_CLOCKS_OUT[g])
            else $error("frozen output not held low");

        chk_run_follows: assert property ( // [R05]
            @(posedge CORE_CLK) disable iff (RST)
            (!RST && c.en[g] && c.gate[g]) |=> (FREEZABLE_CLOCKS_OUT[g] == $past(FREEZABLE_CLOCKS_IN[g])))
            else $error("running output not following its source");

        // a high source cannot shorten or start a pulse, whatever the enable does
        chk_high_pulse_whole: assert property ( // [R09] [R10]
            @(posedge CORE_CLK) disable iff (RST)
            s_src_high_twice |-> ##1 $stable(FREEZABLE_CLOCKS_OUT[g]))
            else $error("output changed inside a source high phase");

        chk_low_src_low_out: assert property ( // [R09]
            @(posedge CORE_CLK) disable iff (RST)
            (!RST && !FREEZABLE_CLOCKS_IN[g]) |=> !FREEZABLE_CLOCKS_OUT[g])
            else $error("output high while its source was low");
    end

endmodule : ofsc_top

/* test/ofsc_frz_driver.sv */
`timescale 1ns/100ps
module ofsc_frz_driver (
    output logic serial_clock,
    output logic serial_data
);
    // ***********************************
    // serial driver model
    // ***********************************
    // clock stands low between frames; released data line reads high
    initial begin
        serial_clock = 1'h0;
        serial_data  = 1'h1;
    end

    task tick(input logic bit_value);
        serial_data = bit_value;
        #15 serial_clock = 1'h1;
        #15 serial_clock = 1'h0;
    endtask : tick

    // chain leaves the apply edge to the start bit of the next frame
    task send(input logic [11:0] word, input logic chain);
        tick(1'h0);
        for (int i = 0; i < 12; i++) tick(word[i]);
        if (!chain) tick(1'h1);
        serial_data = 1'h1;
    endtask : send
endmodule : ofsc_frz_driver

/* test/output_freeze_serial_control_bench.sv */
`timescale 1ns/100ps
module output_freeze_serial_control_bench;
    logic        CORE_CLK = 1'h0;
    logic        RST = 1'h1;
    wire         sclk;
    wire         sdata;
    logic [11:0] src = 12'h000;
    logic [11:0] src_prev = 12'h000;
    logic [1:0]  div = 2'h0;
    logic [11:0] out;
    logic        bank_out;
    logic        fb_out;
    logic [11:0] en;
    logic [11:0] cur;
    logic [2:0]  hi_len [12];
    int          err_count = 0;
    int          checks_done = 0;
    int          cycles = 0;

    always #5 CORE_CLK = ~CORE_CLK;

    ofsc_top i_dut (.CORE_CLK(CORE_CLK), .RST(RST), .FREEZE_SERIAL_CLOCK(sclk), .FREEZE_SERIAL_DATA(sdata),
        .FREEZABLE_CLOCKS_IN(src), .BANK_C_FIRST_IN(src[0]), .FEEDBACK_IN(src[0]), .FREEZABLE_CLOCKS_OUT(out),
        .BANK_C_FIRST_OUTPUT(bank_out), .FEEDBACK_OUTPUT(fb_out), .FREEZE_ENABLES(en));
    ofsc_frz_driver i_drv (.serial_clock(sclk), .serial_data(sdata));

    // ***********************************
    // sources, timeout, pulse monitor
    // ***********************************
    always @(posedge CORE_CLK) begin
        div      <= div + 2'h1;
        src      <= {12{div[1]}};
        src_prev <= src;
        cycles   <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            give_verdict();
        end
    end

    // every high pulse must be a full half period: a runt means a bad gate
    always @(negedge CORE_CLK) begin
        for (int i = 0; i < 12; i++) begin
            if (out[i] === 1'h1) hi_len[i] <= hi_len[i] + 3'h1;
            else begin
                if (!RST && hi_len[i] != 3'h0) check_word({9'h000, hi_len[i]}, 12'h002);
                hi_len[i] <= 3'h0;
            end
        end
    end

    // ***********************************
    // compare and scenarios
    // ***********************************
    task check_word(input logic [11:0] got, input logic [11:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check_word

    task settle_check(input logic [11:0] w);
        repeat (8) @(negedge CORE_CLK);
        check_word(en, w);
        repeat (4) begin
            @(negedge CORE_CLK);
            check_word(out, src_prev & w);
            check_word({10'h000, bank_out, fb_out}, {10'h000, src_prev[0], src_prev[0]});
        end
    endtask : settle_check

    task test_word(input logic [11:0] w);
        fork
            i_drv.send(w, 1'h0);
            begin
                #300;
                @(negedge CORE_CLK);
                check_word(en, cur);
            end
        join
        settle_check(w);
        cur = w;
    endtask : test_word

    task test_chain(input logic [11:0] a, input logic [11:0] b);
        fork
            begin
                i_drv.send(a, 1'h1);
                i_drv.send(b, 1'h0);
            end
            begin
                #590;
                @(negedge CORE_CLK);
                check_word(en, a);
            end
        join
        settle_check(b);
        cur = b;
    endtask : test_chain

    task test_idle;
        repeat (6) i_drv.tick(1'h1);
        repeat (6) @(negedge CORE_CLK);
        check_word(en, cur);
    endtask : test_idle

    task give_verdict;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (4) i_drv.tick(1'h1);
        @(posedge CORE_CLK);
        RST <= 1'h0;
        repeat (3) i_drv.tick(1'h1);
        @(negedge CORE_CLK);
        check_word(en, 12'hFFF);
        cur = 12'hFFF;
        for (int i = 0; i < 12; i++) test_word(~(12'h001 << i));
        test_word(12'h000);
        test_chain(12'hA5C, 12'hFFF);
        test_idle();
        test_word(12'h3C3);
        give_verdict();
    end
endmodule : output_freeze_serial_control_bench
